// >>> common/fsp_pkg.sv
// Package with field positions, instruction codes and reset values for the status block
package fsp_pkg;
  // Instruction codes
  localparam logic [7:0] INS_WREN = 8'h06;
  localparam logic [7:0] INS_WREN_VOL = 8'h50;
  localparam logic [7:0] INS_WRDI = 8'h04;
  localparam logic [7:0] INS_WRSR1 = 8'h01;
  localparam logic [7:0] INS_WRSR2 = 8'h31;
  localparam logic [7:0] INS_WRSR3 = 8'h11;
  localparam logic [7:0] INS_RDSR1 = 8'h05;
  localparam logic [7:0] INS_RDSR2 = 8'h35;
  localparam logic [7:0] INS_RDSR3 = 8'h15;
  localparam logic [7:0] INS_SUSPEND = 8'h75;
  localparam logic [7:0] INS_RESUME = 8'h7a;
  localparam logic [7:0] INS_PROGRAM = 8'h02;
  localparam logic [7:0] INS_ERASE_SEC = 8'h20;
  localparam logic [7:0] INS_ERASE_BLK = 8'hd8;
  localparam logic [7:0] INS_ERASE_CHIP = 8'hc7;
  localparam logic [7:0] INS_SW_RESET = 8'h99;
  // Status register selectors on the write data path
  localparam logic [1:0] SEL_FIRST = 2'h0;
  localparam logic [1:0] SEL_SECOND = 2'h1;
  localparam logic [1:0] SEL_THIRD = 2'h2;
  // Writable masks for non-volatile and volatile images
  localparam logic [7:0] FIRST_WR_MASK = 8'hfc;
  localparam logic [7:0] SECOND_NV_MASK = 8'h7b;
  localparam logic [7:0] SECOND_VOL_MASK = 8'h43;
  localparam logic [7:0] THIRD_NV_MASK = 8'h90;
  localparam logic [7:0] THIRD_VOL_MASK = 8'hf0;
  // Field positions
  localparam int BUSY_BIT = 0;
  localparam int WLATCH_BIT = 1;
  localparam int GUARD_LOWER_BIT = 7;
  localparam int GUARD_UPPER_BIT = 0;
  localparam int QUAD_BIT = 1;
  localparam int PAUSE_BIT = 7;
  localparam int LOCK_LSB = 2;
  localparam int PIN_FUNC_BIT = 7;
  localparam int FAST_BIT = 4;
  localparam int DRIVE_LSB = 5;
  // Factory values: lock zero preset, drive code 10
  localparam logic [7:0] FIRST_FACTORY = 8'h00;
  localparam logic [7:0] SECOND_FACTORY = 8'h04;
  localparam logic [7:0] THIRD_FACTORY = 8'h40;
  localparam logic [1:0] DRIVE_RESET = 2'h2;
  // Embedded write time in clock cycles
  localparam int unsigned BUSY_CYCLES = 16;
endpackage : fsp_pkg

// >>> src/fsp_status.sv
// Status register fields, protection modes and lock bits of a serial flash
// What this block does
// - Non-volatile three-bit range field, first bits 4:2
// - Direction bit first bit 5, zero means top
// - Unit bit first bit 6, one means sector
// - Invert bit second bit 6 swaps regions
// - Guard mode bits second bit 0, first bit 7
// - Mode 00: pin ignored, latch enables writes
// - Mode 01: pin low locks registers while quad bit off
// - Mode 10: locked until reset, then 00
// - Mode 11: writes refused for ever
// - Busy, latch, pause flag read-only, untouched
// - After 06h status write targets non-volatile
// - After 50h status write targets volatile copies
// - Lock bits have no volatile copy
// - Pause flag set 75h, cleared 7Ah
// - Lock bits settable once, lock security register
// - Lock zero preset to one
// - Quad bit turns pins into data lines
// - Shared pin hold or reset when quad off
// - Drive code strengths, reset value 10
// - Fast quad mode bit, default zero
// - Busy during write; only status read accepted
// - Latch set by 06h, cleared by writes
module fsp_status (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // Decoded instruction strobe from the serial front end
  input wire logic INS_VALID,
  input wire logic [7:0] INS_CODE,
  input wire logic [1:0] INS_SEL,
  input wire logic [7:0] INS_DATA,
  // Completion of program or erase in the array
  input wire logic ARRAY_DONE,
  // Write-protect pin
  input wire logic WP_N_PIN,
  // Status read data
  output logic [7:0] RD_DATA,
  // Effective configuration
  output logic [2:0] RANGE_BITS,
  output logic RANGE_DIRECTION,
  output logic RANGE_UNIT_SMALL,
  output logic RANGE_INVERT,
  output logic [3:0] OTP_LOCKS,
  output logic QUAD_LINES_ON,
  output logic HOLD_ACTIVE,
  output logic RESET_PIN_ACTIVE,
  output logic [1:0] DRIVE_CODE,
  output logic FAST_QUAD_MODE,
  output logic BUSY,
  output logic WRITE_LATCH,
  output logic PAUSE_FLAG
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARRAY = 3'b010,
    ST_STATUS = 3'b100
  } fsp_state_type;

  fsp_state_type state, next_state;
  logic [7:0] nv_first, nv_second, nv_third;
  logic [7:0] vol_first, vol_second, vol_third;
  logic [7:0] next_nv_first, next_nv_second, next_nv_third;
  logic [7:0] next_vol_first, next_vol_second, next_vol_third;
  logic write_latch, next_write_latch, vol_target, next_vol_target;
  logic pause_flag, next_pause_flag;
  logic [4:0] count, next_count;
  logic [2:0] wp_sync;
  logic wp_level, next_wp_level;
  logic [7:0] rd_data, next_rd_data;
  logic writable;

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] val,
                                       input logic [7:0] mask);
    merge = (old & ~mask) | (val & mask);
  endfunction : merge

  // Pin synchroniser, change taken when last two stages agree
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      wp_sync <= 3'h7;
      wp_level <= 1'b1;
    end
    else
    begin
      wp_sync <= {wp_sync[1:0], WP_N_PIN};
      wp_level <= next_wp_level;
    end
  end

  always_comb
  begin
    next_wp_level = wp_level;
    if (wp_sync[1] == wp_sync[2])
    begin
      next_wp_level = wp_sync[2];
    end
  end

  // Guard mode decides whether status writes are allowed
  always_comb
  begin
    logic [1:0] mode;
    mode = {vol_second[fsp_pkg::GUARD_UPPER_BIT], vol_first[fsp_pkg::GUARD_LOWER_BIT]};
    case (mode)
      2'h0: writable = write_latch;
      2'h1: writable = write_latch && (wp_level || vol_second[fsp_pkg::QUAD_BIT]);
      2'h2: writable = 1'b0;
      default: writable = 1'b0;
    endcase
  end

  always_comb
  begin
    logic [7:0] nv_mask;
    logic [7:0] vol_mask;
    logic [7:0] locks_new;
    next_state = state;
    next_count = count;
    next_nv_first = nv_first;
    next_nv_second = nv_second;
    next_nv_third = nv_third;
    next_vol_first = vol_first;
    next_vol_second = vol_second;
    next_vol_third = vol_third;
    next_write_latch = write_latch;
    next_vol_target = vol_target;
    next_pause_flag = pause_flag;
    next_rd_data = rd_data;
    nv_mask = 8'h00;
    vol_mask = 8'h00;
    locks_new = 8'h00;
    // Read data path, always served
    if (INS_VALID && INS_CODE == fsp_pkg::INS_RDSR1)
      next_rd_data = {vol_first[7:2], write_latch, state != ST_IDLE};
    else if (INS_VALID && INS_CODE == fsp_pkg::INS_RDSR2)
      next_rd_data = {pause_flag, vol_second[6:0]};
    else if (INS_VALID && INS_CODE == fsp_pkg::INS_RDSR3)
      next_rd_data = vol_third;
    case (state)
      ST_IDLE:
      begin
        if (INS_VALID && INS_CODE == fsp_pkg::INS_SW_RESET)
        begin
          // Lock-down mode returns to 00, volatile copies reload
          if (nv_second[fsp_pkg::GUARD_UPPER_BIT] && !nv_first[fsp_pkg::GUARD_LOWER_BIT])
            next_nv_second[fsp_pkg::GUARD_UPPER_BIT] = 1'b0;
          next_vol_first = nv_first;
          next_vol_second = next_nv_second;
          next_vol_third = {nv_third[7], fsp_pkg::DRIVE_RESET, nv_third[4:0]};
          next_write_latch = 1'b0;
          next_vol_target = 1'b0;
        end
        else if (INS_VALID && INS_CODE == fsp_pkg::INS_WREN)
        begin
          next_write_latch = 1'b1;
          next_vol_target = 1'b0;
        end
        else if (INS_VALID && INS_CODE == fsp_pkg::INS_WREN_VOL)
        begin
          next_write_latch = 1'b1;
          next_vol_target = 1'b1;
        end
        else if (INS_VALID && INS_CODE == fsp_pkg::INS_WRDI)
          next_write_latch = 1'b0;
        else if (INS_VALID && INS_CODE == fsp_pkg::INS_SUSPEND)
          next_pause_flag = 1'b1;
        else if (INS_VALID && INS_CODE == fsp_pkg::INS_RESUME)
          next_pause_flag = 1'b0;
        else if (INS_VALID && (INS_CODE == fsp_pkg::INS_PROGRAM
                 || INS_CODE == fsp_pkg::INS_ERASE_SEC || INS_CODE == fsp_pkg::INS_ERASE_BLK
                 || INS_CODE == fsp_pkg::INS_ERASE_CHIP) && write_latch)
        begin
          next_write_latch = 1'b0;
          next_state = ST_ARRAY;
        end
        else if (INS_VALID && (INS_CODE == fsp_pkg::INS_WRSR1
                 || INS_CODE == fsp_pkg::INS_WRSR2 || INS_CODE == fsp_pkg::INS_WRSR3))
        begin
          if (writable)
          begin
            // Busy, latch and pause flag never written
            if (INS_SEL == fsp_pkg::SEL_FIRST)
            begin
              nv_mask = fsp_pkg::FIRST_WR_MASK;
              vol_mask = fsp_pkg::FIRST_WR_MASK;
            end
            else if (INS_SEL == fsp_pkg::SEL_SECOND)
            begin
              nv_mask = fsp_pkg::SECOND_NV_MASK;
              vol_mask = fsp_pkg::SECOND_VOL_MASK;
            end
            if (vol_target)
            begin
              if (INS_SEL == fsp_pkg::SEL_FIRST)
                next_vol_first = merge(vol_first, INS_DATA, vol_mask);
              else if (INS_SEL == fsp_pkg::SEL_SECOND)
                next_vol_second = merge(vol_second, INS_DATA, vol_mask);
              else
                next_vol_third = merge(vol_third, INS_DATA, fsp_pkg::THIRD_VOL_MASK);
            end
            else
            begin
              if (INS_SEL == fsp_pkg::SEL_FIRST)
              begin
                next_nv_first = merge(nv_first, INS_DATA, nv_mask);
                next_vol_first = merge(vol_first, INS_DATA, nv_mask);
              end
              else if (INS_SEL == fsp_pkg::SEL_SECOND)
              begin
                // Lock bits only ever go from 0 to 1
                locks_new = nv_second | (INS_DATA & 8'h3c);
                next_nv_second = merge(locks_new, INS_DATA, fsp_pkg::SECOND_VOL_MASK);
                next_vol_second = merge(vol_second, next_nv_second, nv_mask);
              end
              else
              begin
                next_nv_third = merge(nv_third, INS_DATA, fsp_pkg::THIRD_NV_MASK);
                next_vol_third = merge(vol_third, INS_DATA, fsp_pkg::THIRD_NV_MASK);
              end
            end
            next_count = 5'(fsp_pkg::BUSY_CYCLES);
            next_state = ST_STATUS;
          end
          next_write_latch = 1'b0;
        end
      end
      ST_ARRAY:
      begin
        if (ARRAY_DONE)
          next_state = ST_IDLE;
      end
      ST_STATUS:
      begin
        next_count = count - 5'h01;
        if (count == 5'h01)
          next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state <= ST_IDLE;
      count <= 5'h00;
      nv_first <= fsp_pkg::FIRST_FACTORY;
      nv_second <= fsp_pkg::SECOND_FACTORY;
      nv_third <= fsp_pkg::THIRD_FACTORY;
      vol_first <= fsp_pkg::FIRST_FACTORY;
      vol_second <= fsp_pkg::SECOND_FACTORY;
      vol_third <= fsp_pkg::THIRD_FACTORY;
      write_latch <= 1'b0;
      vol_target <= 1'b0;
      pause_flag <= 1'b0;
      rd_data <= 8'h00;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
      nv_first <= next_nv_first;
      nv_second <= next_nv_second;
      nv_third <= next_nv_third;
      vol_first <= next_vol_first;
      vol_second <= next_vol_second;
      vol_third <= next_vol_third;
      write_latch <= next_write_latch;
      vol_target <= next_vol_target;
      pause_flag <= next_pause_flag;
      rd_data <= next_rd_data;
    end
  end

  // Registered outputs from the effective copies
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      RD_DATA <= 8'h00;
      RANGE_BITS <= 3'h0;
      RANGE_DIRECTION <= 1'b0;
      RANGE_UNIT_SMALL <= 1'b0;
      RANGE_INVERT <= 1'b0;
      OTP_LOCKS <= 4'h1;
      QUAD_LINES_ON <= 1'b0;
      HOLD_ACTIVE <= 1'b1;
      RESET_PIN_ACTIVE <= 1'b0;
      DRIVE_CODE <= fsp_pkg::DRIVE_RESET;
      FAST_QUAD_MODE <= 1'b0;
      BUSY <= 1'b0;
      WRITE_LATCH <= 1'b0;
      PAUSE_FLAG <= 1'b0;
    end
    else
    begin
      RD_DATA <= rd_data;
      RANGE_BITS <= vol_first[4:2];
      RANGE_DIRECTION <= vol_first[5];
      RANGE_UNIT_SMALL <= vol_first[6];
      RANGE_INVERT <= vol_second[6];
      OTP_LOCKS <= nv_second[fsp_pkg::LOCK_LSB +: 4];
      QUAD_LINES_ON <= vol_second[fsp_pkg::QUAD_BIT];
      HOLD_ACTIVE <= !vol_second[fsp_pkg::QUAD_BIT] && !vol_third[fsp_pkg::PIN_FUNC_BIT];
      RESET_PIN_ACTIVE <= !vol_second[fsp_pkg::QUAD_BIT] && vol_third[fsp_pkg::PIN_FUNC_BIT];
      DRIVE_CODE <= vol_third[fsp_pkg::DRIVE_LSB +: 2];
      FAST_QUAD_MODE <= vol_third[fsp_pkg::FAST_BIT];
      BUSY <= state != ST_IDLE;
      WRITE_LATCH <= write_latch;
      PAUSE_FLAG <= pause_flag;
    end
  end
endmodule : fsp_status

// >>> verification/fsp_host.sv
// Host model issuing decoded status instructions
module fsp_host (
  // Clock
  input wire logic clk,
  // Instruction port
  output logic ins_valid,
  output logic [7:0] ins_code,
  output logic [1:0] ins_sel,
  output logic [7:0] ins_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    ins_valid = 1'b0;
    ins_code = 8'h00;
    ins_sel = 2'h0;
    ins_data = 8'h00;
  end
  // One instruction, code and data scrambled when idle
  task automatic send(input logic [7:0] c, input logic [1:0] s, input logic [7:0] d);
    @(negedge clk);
    ins_valid = 1'b1;
    ins_code = c;
    ins_sel = s;
    ins_data = d;
    @(negedge clk);
    ins_valid = 1'b0;
    ins_code = ~c;
    ins_data = ~d;
  endtask : send
endmodule : fsp_host

// >>> verification/fsp_status_asserts.sv
// Checker for status block port behaviour
module fsp_status_asserts (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // Watched ports
  input wire logic INS_VALID,
  input wire logic [7:0] INS_CODE,
  input wire logic [2:0] RANGE_BITS,
  input wire logic [3:0] OTP_LOCKS,
  input wire logic QUAD_LINES_ON,
  input wire logic HOLD_ACTIVE,
  input wire logic RESET_PIN_ACTIVE,
  input wire logic BUSY,
  input wire logic WRITE_LATCH,
  input wire logic PAUSE_FLAG
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);
  property p_take(c, o);
    INS_VALID && !BUSY && !$past(INS_VALID) && INS_CODE == c |-> ##2 o;
  endproperty
  a_latch_set: assert property (p_take(fsp_pkg::INS_WREN, WRITE_LATCH))
    else $error("latch not set");
  a_latch_clear: assert property (p_take(fsp_pkg::INS_WRDI, !WRITE_LATCH))
    else $error("latch not cleared");
  a_pause_set: assert property (p_take(fsp_pkg::INS_SUSPEND, PAUSE_FLAG))
    else $error("pause flag not set");
  a_pause_clear: assert property (p_take(fsp_pkg::INS_RESUME, !PAUSE_FLAG))
    else $error("pause flag not cleared");
  a_unlatched_write: assert property (INS_VALID && !BUSY && !WRITE_LATCH && !$past(INS_VALID)
    && INS_CODE == fsp_pkg::INS_WRSR1 |-> ##1 $stable(RANGE_BITS) [*3])
    else $error("write taken without latch");
  a_busy_ignore: assert property ((INS_VALID && INS_CODE == fsp_pkg::INS_WREN) ##1 BUSY
    |-> ##1 !WRITE_LATCH)
    else $error("instruction taken while busy");
  a_locks_keep: assert property ((OTP_LOCKS & $past(OTP_LOCKS)) == $past(OTP_LOCKS))
    else $error("lock bit cleared");
  a_lock_zero: assert property (OTP_LOCKS[0])
    else $error("lock zero not set");
  a_quad_pins: assert property (QUAD_LINES_ON |-> !HOLD_ACTIVE && !RESET_PIN_ACTIVE)
    else $error("pin function active in quad");
  a_pin_choice: assert property (!QUAD_LINES_ON |-> HOLD_ACTIVE != RESET_PIN_ACTIVE)
    else $error("shared pin function wrong");
  cover property (INS_VALID && INS_CODE == fsp_pkg::INS_SW_RESET);
  cover property ($rose(BUSY));
  cover property ($rose(QUAD_LINES_ON));
endmodule : fsp_status_asserts

// >>> verification/test_fsp_status.sv
// Bench for the status block: instruction sequences with expected fields
bind fsp_status fsp_status_asserts i_chk (.MCLK(MCLK), .RST_N(RST_N), .INS_VALID(INS_VALID),
  .INS_CODE(INS_CODE), .RANGE_BITS(RANGE_BITS), .OTP_LOCKS(OTP_LOCKS),
  .QUAD_LINES_ON(QUAD_LINES_ON), .HOLD_ACTIVE(HOLD_ACTIVE), .RESET_PIN_ACTIVE(RESET_PIN_ACTIVE),
  .BUSY(BUSY), .WRITE_LATCH(WRITE_LATCH), .PAUSE_FLAG(PAUSE_FLAG));
module test_fsp_status;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] WRC [0:2] = '{fsp_pkg::INS_WRSR1, fsp_pkg::INS_WRSR2, fsp_pkg::INS_WRSR3};
  localparam logic [7:0] RDC [0:2] = '{fsp_pkg::INS_RDSR1, fsp_pkg::INS_RDSR2, fsp_pkg::INS_RDSR3};
  localparam logic [7:0] ARC [0:3] = '{fsp_pkg::INS_PROGRAM, fsp_pkg::INS_ERASE_SEC,
    fsp_pkg::INS_ERASE_BLK, fsp_pkg::INS_ERASE_CHIP};
  logic clk, rst_n, v, done, wp_n, qo, ho, ro, fo, io, uo, dro, bo, lo, po;
  logic [7:0] code, data, rd_data;
  logic [1:0] sel, drv;
  logic [2:0] rb;
  logic [3:0] lk;
  logic [15:0] cfg, flg;
  int error_cnt = 0;
  int n_checks = 0;
  int cycles = 0;
  assign cfg = {lk, qo, ho, ro, drv, fo, io, uo, dro, rb};
  assign flg = {13'h0000, bo, lo, po};
  fsp_host i_host (.clk(clk), .ins_valid(v), .ins_code(code), .ins_sel(sel), .ins_data(data));
  fsp_status i_dut (.MCLK(clk), .RST_N(rst_n), .INS_VALID(v), .INS_CODE(code), .INS_SEL(sel),
    .INS_DATA(data), .ARRAY_DONE(done), .WP_N_PIN(wp_n), .RD_DATA(rd_data), .RANGE_BITS(rb),
    .RANGE_DIRECTION(dro), .RANGE_UNIT_SMALL(uo), .RANGE_INVERT(io), .OTP_LOCKS(lk),
    .QUAD_LINES_ON(qo), .HOLD_ACTIVE(ho), .RESET_PIN_ACTIVE(ro), .DRIVE_CODE(drv),
    .FAST_QUAD_MODE(fo), .BUSY(bo), .WRITE_LATCH(lo), .PAUSE_FLAG(po));
  task automatic results;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask : wt
  task automatic wr(input logic nv, input logic [1:0] s, input logic [7:0] d);
    i_host.send(nv ? fsp_pkg::INS_WREN : fsp_pkg::INS_WREN_VOL, 2'h0, 8'h00);
    i_host.send(WRC[s], s, d);
    wt(22);
  endtask : wr
  task automatic rd(input logic [1:0] s, input logic [7:0] e);
    i_host.send(RDC[s], s, 8'h00);
    wt(2);
    check({8'h00, rd_data}, {8'h00, e});
  endtask : rd
  task automatic cmd(input logic [7:0] c);
    i_host.send(c, 2'h0, 8'h00);
    wt(3);
  endtask : cmd
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      error_cnt++;
      results;
    end
  end
  initial
  begin
    rst_n = 1'b0;
    done = 1'b0;
    wp_n = 1'b1;
    wt(4);
    rst_n = 1'b1;
    check(cfg, 16'h1500);
    rd(2'h0, 8'h00);
    rd(2'h1, 8'h04);
    rd(2'h2, 8'h40);
    i_host.send(fsp_pkg::INS_WRSR1, 2'h0, 8'hfc);
    wt(22);
    check(cfg, 16'h1500);
    wr(1'b1, 2'h0, 8'h7c);
    check(cfg, 16'h151f);
    rd(2'h0, 8'h7c);
    i_host.send(fsp_pkg::INS_WREN, 2'h0, 8'h00);
    i_host.send(fsp_pkg::INS_WRSR1, 2'h0, 8'h00);
    wt(2);
    check(flg, 16'h0004);
    i_host.send(fsp_pkg::INS_WREN, 2'h0, 8'h00);
    rd(2'h0, 8'h01);
    wt(16);
    check(flg, 16'h0000);
    wr(1'b1, 2'h1, 8'h48);
    check(cfg, 16'h3520);
    wr(1'b1, 2'h1, 8'h00);
    check(cfg, 16'h3500);
    for (int d = 0; d < 4; d++)
    begin
      wr(1'b0, 2'h2, {1'b0, 2'(d), 5'h00});
      check(cfg, 16'h3400 | {7'h00, 2'(d), 7'h00});
    end
    wr(1'b0, 2'h2, 8'hf0);
    check(cfg, 16'h33c0);
    wr(1'b0, 2'h1, 8'h3e);
    check(cfg, 16'h39c0);
    cmd(fsp_pkg::INS_SW_RESET);
    check(cfg, 16'h3500);
    wr(1'b1, 2'h0, 8'h80);
    rd(2'h0, 8'h80);
    wp_n = 1'b0;
    wt(5);
    wr(1'b1, 2'h0, 8'h84);
    check(cfg, 16'h3500);
    wp_n = 1'b1;
    wt(5);
    wr(1'b1, 2'h0, 8'h84);
    check(cfg, 16'h3501);
    wr(1'b1, 2'h0, 8'h04);
    wr(1'b1, 2'h1, 8'h01);
    rd(2'h1, 8'h0d);
    wr(1'b1, 2'h0, 8'h00);
    check(cfg, 16'h3501);
    cmd(fsp_pkg::INS_SW_RESET);
    rd(2'h1, 8'h0c);
    wr(1'b1, 2'h0, 8'h00);
    check(cfg, 16'h3500);
    cmd(fsp_pkg::INS_SUSPEND);
    check(flg, 16'h0001);
    wr(1'b1, 2'h1, 8'h80);
    check(flg, 16'h0001);
    cmd(fsp_pkg::INS_RESUME);
    check(flg, 16'h0000);
    cmd(fsp_pkg::INS_WREN);
    check(flg, 16'h0002);
    cmd(fsp_pkg::INS_WRDI);
    check(flg, 16'h0000);
    cmd(fsp_pkg::INS_ERASE_CHIP);
    check(flg, 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      cmd(fsp_pkg::INS_WREN);
      cmd(ARC[i]);
      check(flg, 16'h0004);
      cmd(fsp_pkg::INS_WREN);
      check(flg, 16'h0004);
      done = 1'b1;
      wt(1);
      done = 1'b0;
      wt(3);
      check(flg, 16'h0000);
    end
    wr(1'b1, 2'h0, 8'h80);
    wr(1'b1, 2'h1, 8'h01);
    cmd(fsp_pkg::INS_SW_RESET);
    wr(1'b1, 2'h0, 8'h04);
    check(cfg, 16'h3500);
    cmd(fsp_pkg::INS_SUSPEND);
    rst_n = 1'b0;
    wt(4);
    rst_n = 1'b1;
    check(flg, 16'h0000);
    check(cfg, 16'h1500);
    rd(2'h1, 8'h04);
    results;
  end
endmodule : test_fsp_status
